// file: hw/pjr_pkg.sv
package pjr_pkg;

  localparam int DW    = 16;
  localparam int AW    = 6;
  localparam int NIN   = 8;
  localparam int FW    = 4;
  localparam int NPRE  = 7;
  localparam int NJOG  = 3;
  localparam int NRATE = 8;
  localparam int NFN   = 7;

  // register word addresses
  localparam logic [AW-1:0] A_PRESET0 = 6'h00;
  localparam logic [AW-1:0] A_JOG0    = 6'h08;
  localparam logic [AW-1:0] A_MAIN    = 6'h0C;
  localparam logic [AW-1:0] A_JMODE   = 6'h0D;
  localparam logic [AW-1:0] A_CMODE   = 6'h0E;
  localparam logic [AW-1:0] A_FN0     = 6'h10;
  localparam logic [AW-1:0] A_RATE0   = 6'h18;
  localparam logic [AW-1:0] A_STATUS  = 6'h20;

  // digital input function codes
  localparam logic [FW-1:0] FN_NONE   = 4'h0;
  localparam logic [FW-1:0] FN_PSA    = 4'h1;
  localparam logic [FW-1:0] FN_PSB    = 4'h2;
  localparam logic [FW-1:0] FN_PSC    = 4'h3;
  localparam logic [FW-1:0] FN_FOLLOW = 4'h6;
  localparam logic [FW-1:0] FN_REV    = 4'h7;
  localparam logic [FW-1:0] FN_JOG_SEL_BIT_A   = 4'hC;
  localparam logic [FW-1:0] FN_JOG_SEL_BIT_B   = 4'hD;

  localparam int FI_PSA = 0;
  localparam int FI_PSB = 1;
  localparam int FI_PSC = 2;
  localparam int FI_FOL = 3;
  localparam int FI_REV = 4;
  localparam int FI_JGA = 5;
  localparam int FI_JGB = 6;
  localparam logic [FW-1:0] FN_CODES [NFN] = '{FN_PSA, FN_PSB, FN_PSC,
      FN_FOLLOW, FN_REV, FN_JOG_SEL_BIT_A, FN_JOG_SEL_BIT_B};

  localparam logic [FW-1:0] CMODE_IREF = 4'h3;
  localparam logic [FW-1:0] CMODE_RST  = 4'h0;

  localparam logic [1:0] JMODE_COMMON   = 2'h0;
  localparam logic [1:0] JMODE_DIRECT   = 2'h1;
  localparam logic [1:0] JMODE_SEPARATE = 2'h2;
  localparam logic [1:0] JMODE_RST      = JMODE_COMMON;

  // references in hundredths of a percent
  localparam logic signed [DW-1:0] REF_MAX = 16'sh2710;
  localparam logic signed [DW-1:0] REF_MIN = 16'shD8F0;
  localparam logic [DW-1:0] PRESET_RST [NPRE] = '{16'h01F4, 16'h07D0,
      16'h03E8, 16'h0000, 16'hFE0C, 16'hF830, 16'hFC18};
  localparam logic [DW-1:0] JOG_RST [NJOG] = '{16'h01F4, 16'hFE0C,
      16'h0000};
  localparam logic [DW-1:0] MAIN_RST = 16'h0000;

  // ramp step per tick, index into the rate bank
  localparam int R_ACC_POS  = 0;
  localparam int R_DEC_POS  = 1;
  localparam int R_ACC_NEG  = 2;
  localparam int R_DEC_NEG  = 3;
  localparam int R_STOP_POS = 4;
  localparam int R_STOP_NEG = 5;
  localparam int R_JOG_ACC  = 6;
  localparam int R_JOG_DEC  = 7;
  localparam logic [DW-1:0] RATE_RST = 16'h000A;

  localparam int CLK_NS   = 100;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  localparam int ST_PAD_W = 4;

  typedef enum logic [1:0] {
    JST_IDLE = 2'b00,
    JST_JOG  = 2'b01,
    JST_STOP = 2'b10
  } pjr_jog_state_t;

endpackage : pjr_pkg

// file: hw/pjr_fn_match.sv
module pjr_fn_match #(
  parameter int N  = 8,
  parameter int FW = 4
) (
  input  wire logic [N-1:0]    din_in,
  input  wire logic [N*FW-1:0] cfg_in,
  input  wire logic [FW-1:0]   code_in,
  output logic                 hit_out
);

  // a function nobody is assigned to reads as open
  always_comb begin
    hit_out = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (din_in[i] && cfg_in[i*FW +: FW] == code_in) begin
        hit_out = 1'b1;
      end
    end
  end

endmodule : pjr_fn_match

// file: hw/pjr_ramp.sv
module pjr_ramp #(
  parameter int DW = 16
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 tick_in,
  input  wire logic                 bypass_in,
  input  wire logic signed [DW-1:0] target_in,
  input  wire logic [DW-1:0]        up_step_in,
  input  wire logic [DW-1:0]        dn_step_in,
  output logic signed [DW-1:0]      level_out
);

  logic signed [DW-1:0] level_q;
  logic signed [DW-1:0] level_d;
  logic signed [DW:0]   diff;
  logic [DW:0]          mag;
  logic [DW:0]          step;
  logic                 rising;

  always_comb begin
    diff   = (DW+1)'(target_in) - (DW+1)'(level_q);
    rising = diff > 0;
    mag    = rising ? diff : -diff;
    // magnitude grows when moving away from zero
    if (rising ? (level_q >= 0) : (level_q <= 0)) begin
      step = {1'b0, up_step_in};
    end else begin
      step = {1'b0, dn_step_in};
    end
    level_d = level_q;
    if (bypass_in) begin
      level_d = target_in;
    end else if (tick_in) begin
      if (mag <= step) begin
        level_d = target_in;
      end else if (rising) begin
        level_d = DW'(level_q + step[DW-1:0]);
      end else begin
        level_d = DW'(level_q - step[DW-1:0]);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule : pjr_ramp

// file: hw/pjr_preset_jog_select.sv
// Behaviour
// [RULE1] seven preset references, each held within minus to plus 100 percent
// [RULE2] a selected preset replaces the main reference as setpoint
// [RULE3] reverse function flips the sign of the selected reference
// [RULE4] follower input or control mode 3 marks reference as current
// [RULE5] outside controller must close run input while a preset applies
// [RULE6] preset selector input not assigned to a terminal reads open
// [RULE7] inputs with codes 1, 2, 3 drive selector bits A, B, C
// [RULE8] only A and B assigned gives three presets; only A gives one
// [RULE9] C,B,A binary: zero picks main reference, n picks preset n
// [RULE10] jog ramp mode holds 0 to 2, reset value 0
// [RULE11] mode 0 jog uses shared ramps; release uses polarity stop ramp
// [RULE12] mode 1 jog reference goes straight to output
// [RULE13] mode 2 jog uses its own acceleration and deceleration ramps
// [RULE14] mode 2 uses jog deceleration on falling magnitude and release
// [RULE15] inputs with codes 12 and 13 drive jog selector bits A, B
//
// The register addresses and the plain strobed port are this design's own decisions.
module pjr_preset_jog_select #(
  parameter int TICK_CYCLES = pjr_pkg::TICK_CYC
) (
  input  wire logic                     clock_in,
  input  wire logic                     rst_b_in,
  input  wire logic [pjr_pkg::AW-1:0]   reg_addr_in,
  input  wire logic [pjr_pkg::DW-1:0]   reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [pjr_pkg::DW-1:0]   reg_rdata_out,
  input  wire logic [pjr_pkg::NIN-1:0]  din_in,
  input  wire logic                     run_in,
  output logic signed [pjr_pkg::DW-1:0] ref_out,
  output logic                          ref_is_current_out,
  output logic                          preset_active_out,
  output logic                          jog_active_out
);

  localparam int DW = pjr_pkg::DW;
  localparam int FW = pjr_pkg::FW;
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [DW-1:0]                  preset_q [pjr_pkg::NPRE];
  logic [DW-1:0]                  preset_d [pjr_pkg::NPRE];
  logic [DW-1:0]                  jog_q    [pjr_pkg::NJOG];
  logic [DW-1:0]                  jog_d    [pjr_pkg::NJOG];
  logic [DW-1:0]                  rate_q   [pjr_pkg::NRATE];
  logic [DW-1:0]                  rate_d   [pjr_pkg::NRATE];
  logic [pjr_pkg::NIN-1:0][FW-1:0] fn_q;
  logic [pjr_pkg::NIN-1:0][FW-1:0] fn_d;
  logic [DW-1:0]                  main_q;
  logic [DW-1:0]                  main_d;
  logic [1:0]                     jmode_q;
  logic [1:0]                     jmode_d;
  logic [FW-1:0]                  cmode_q;
  logic [FW-1:0]                  cmode_d;
  logic [DW-1:0]                  rdata_q;
  logic [DW-1:0]                  rdata_d;
  logic [pjr_pkg::NFN-1:0]        hit;
  logic [2:0]                     sel;
  logic [1:0]                     jsel;
  logic                           jog_on;
  logic                           is_current;
  logic signed [DW-1:0]           sel_ref;
  logic signed [DW-1:0]           jog_ref;
  logic signed [DW-1:0]           tgt;
  logic signed [DW-1:0]           level;
  logic [DW-1:0]                  up_step;
  logic [DW-1:0]                  dn_step;
  logic                           bypass;
  logic                           pos;
  logic                           tick;
  logic [TW-1:0]                  tick_q;
  logic [TW-1:0]                  tick_d;
  pjr_pkg::pjr_jog_state_t        jst_q;
  pjr_pkg::pjr_jog_state_t        jst_d;
  logic signed [DW-1:0]           ref_q;
  logic                           cur_q;
  logic                           pre_act_q;
  logic                           jog_act_q;

  function automatic logic [DW-1:0] clamp_ref(input logic [DW-1:0] v);
    if ($signed(v) > pjr_pkg::REF_MAX) begin
      return pjr_pkg::REF_MAX;
    end else if ($signed(v) < pjr_pkg::REF_MIN) begin
      return pjr_pkg::REF_MIN;
    end
    return v;
  endfunction : clamp_ref

  // register file
  always_comb begin
    preset_d = preset_q;
    jog_d    = jog_q;
    rate_d   = rate_q;
    fn_d     = fn_q;
    main_d   = main_q;
    jmode_d  = jmode_q;
    cmode_d  = cmode_q;
    rdata_d  = '0;
    if (reg_wr_in) begin
      for (int i = 0; i < pjr_pkg::NPRE; i++) begin
        if (reg_addr_in == pjr_pkg::A_PRESET0 + 6'(i)) begin
          preset_d[i] = clamp_ref(reg_wdata_in); // [RULE1]
        end
      end
      for (int i = 0; i < pjr_pkg::NJOG; i++) begin
        if (reg_addr_in == pjr_pkg::A_JOG0 + 6'(i)) begin
          jog_d[i] = clamp_ref(reg_wdata_in);
        end
      end
      for (int i = 0; i < pjr_pkg::NRATE; i++) begin
        if (reg_addr_in == pjr_pkg::A_RATE0 + 6'(i)) begin
          rate_d[i] = reg_wdata_in;
        end
      end
      for (int i = 0; i < pjr_pkg::NIN; i++) begin
        if (reg_addr_in == pjr_pkg::A_FN0 + 6'(i)) begin
          fn_d[i] = reg_wdata_in[FW-1:0];
        end
      end
      if (reg_addr_in == pjr_pkg::A_MAIN) begin
        main_d = clamp_ref(reg_wdata_in);
      end
      // jog mode writes with 3 in the low two bits are ignored; the upper data bits are dropped
      if (reg_addr_in == pjr_pkg::A_JMODE &&
          reg_wdata_in[1:0] <= pjr_pkg::JMODE_SEPARATE) begin
        jmode_d = reg_wdata_in[1:0]; // [RULE10]
      end
      if (reg_addr_in == pjr_pkg::A_CMODE) begin
        cmode_d = reg_wdata_in[FW-1:0];
      end
    end
    if (reg_rd_in) begin
      for (int i = 0; i < pjr_pkg::NPRE; i++) begin
        if (reg_addr_in == pjr_pkg::A_PRESET0 + 6'(i)) begin
          rdata_d = preset_q[i];
        end
      end
      for (int i = 0; i < pjr_pkg::NJOG; i++) begin
        if (reg_addr_in == pjr_pkg::A_JOG0 + 6'(i)) begin
          rdata_d = jog_q[i];
        end
      end
      for (int i = 0; i < pjr_pkg::NRATE; i++) begin
        if (reg_addr_in == pjr_pkg::A_RATE0 + 6'(i)) begin
          rdata_d = rate_q[i];
        end
      end
      for (int i = 0; i < pjr_pkg::NIN; i++) begin
        if (reg_addr_in == pjr_pkg::A_FN0 + 6'(i)) begin
          rdata_d = DW'(fn_q[i]);
        end
      end
      if (reg_addr_in == pjr_pkg::A_MAIN) begin
        rdata_d = main_q;
      end
      if (reg_addr_in == pjr_pkg::A_JMODE) begin
        rdata_d = DW'(jmode_q);
      end
      if (reg_addr_in == pjr_pkg::A_CMODE) begin
        rdata_d = DW'(cmode_q);
      end
      if (reg_addr_in == pjr_pkg::A_STATUS) begin
        rdata_d = {{pjr_pkg::ST_PAD_W{1'b0}}, run_in, hit[pjr_pkg::FI_REV],
                   is_current, jsel, sel, jmode_q, jst_q};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < pjr_pkg::NPRE; i++) begin
        preset_q[i] <= pjr_pkg::PRESET_RST[i];
      end
      for (int i = 0; i < pjr_pkg::NJOG; i++) begin
        jog_q[i] <= pjr_pkg::JOG_RST[i];
      end
      for (int i = 0; i < pjr_pkg::NRATE; i++) begin
        rate_q[i] <= pjr_pkg::RATE_RST;
      end
      for (int i = 0; i < pjr_pkg::NIN; i++) begin
        fn_q[i] <= pjr_pkg::FN_NONE;
      end
      main_q  <= pjr_pkg::MAIN_RST;
      jmode_q <= pjr_pkg::JMODE_RST;
      cmode_q <= pjr_pkg::CMODE_RST;
      rdata_q <= '0;
    end else begin
      preset_q <= preset_d;
      jog_q    <= jog_d;
      rate_q   <= rate_d;
      fn_q     <= fn_d;
      main_q   <= main_d;
      jmode_q  <= jmode_d;
      cmode_q  <= cmode_d;
      rdata_q  <= rdata_d;
    end
  end

  // one detector per terminal function
  for (genvar g = 0; g < pjr_pkg::NFN; g++) begin : g_fn
    pjr_fn_match #(
      .N  (pjr_pkg::NIN),
      .FW (FW)
    ) u_match (
      .din_in  (din_in),
      .cfg_in  (fn_q),
      .code_in (pjr_pkg::FN_CODES[g]),
      .hit_out (hit[g])
    ); // [RULE6] [RULE7] [RULE15]
  end

  // reference selection
  always_comb begin
    sel    = {hit[pjr_pkg::FI_PSC], hit[pjr_pkg::FI_PSB],
              hit[pjr_pkg::FI_PSA]}; // [RULE8]
    jsel   = {hit[pjr_pkg::FI_JGB], hit[pjr_pkg::FI_JGA]}; // [RULE15]
    jog_on = jsel != 2'h0;
    is_current = hit[pjr_pkg::FI_FOL] ||
                 cmode_q == pjr_pkg::CMODE_IREF; // [RULE4]
    sel_ref = (sel == 3'h0) ? main_q : preset_q[sel - 3'h1]; // [RULE2] [RULE9]
    jog_ref = jog_on ? jog_q[jsel - 2'h1] : '0;
    if (hit[pjr_pkg::FI_REV]) begin
      sel_ref = -sel_ref; // [RULE3]
      jog_ref = -jog_ref;
    end
  end

  // jog sequencing
  always_comb begin
    jst_d = jst_q;
    unique case (jst_q)
      pjr_pkg::JST_IDLE: begin
        if (jog_on) begin
          jst_d = pjr_pkg::JST_JOG;
        end
      end
      pjr_pkg::JST_JOG: begin
        if (!jog_on) begin
          jst_d = (jmode_q == pjr_pkg::JMODE_DIRECT) ? pjr_pkg::JST_IDLE
                                                     : pjr_pkg::JST_STOP;
        end
      end
      pjr_pkg::JST_STOP: begin
        if (jog_on) begin
          jst_d = pjr_pkg::JST_JOG;
        end else if (level == 0) begin
          jst_d = pjr_pkg::JST_IDLE;
        end
      end
      default: jst_d = pjr_pkg::JST_IDLE;
    endcase
  end

  // ramp target and step choice
  always_comb begin
    unique case (jst_q)
      pjr_pkg::JST_JOG:  tgt = jog_ref;
      pjr_pkg::JST_STOP: tgt = '0;
      default:           tgt = run_in ? sel_ref : '0; // [RULE5]
    endcase
    pos     = (level > 0) || (level == 0 && tgt > 0);
    up_step = pos ? rate_q[pjr_pkg::R_ACC_POS] : rate_q[pjr_pkg::R_ACC_NEG];
    dn_step = pos ? rate_q[pjr_pkg::R_DEC_POS] : rate_q[pjr_pkg::R_DEC_NEG];
    bypass  = 1'b0;
    if (jst_q == pjr_pkg::JST_JOG) begin
      bypass = jmode_q == pjr_pkg::JMODE_DIRECT; // [RULE12]
      if (jmode_q == pjr_pkg::JMODE_SEPARATE) begin
        up_step = rate_q[pjr_pkg::R_JOG_ACC]; // [RULE13]
        dn_step = rate_q[pjr_pkg::R_JOG_DEC]; // [RULE14]
      end
    end else if (jst_q == pjr_pkg::JST_STOP) begin
      if (jmode_q == pjr_pkg::JMODE_SEPARATE) begin
        dn_step = rate_q[pjr_pkg::R_JOG_DEC]; // [RULE14]
      end else begin
        dn_step = pos ? rate_q[pjr_pkg::R_STOP_POS]
                      : rate_q[pjr_pkg::R_STOP_NEG]; // [RULE11]
      end
    end
  end

  // ramp tick divider
  always_comb begin
    tick   = tick_q == TW'(TICK_CYCLES - 1);
    tick_d = tick ? '0 : tick_q + TW'(1);
  end

  pjr_ramp #(
    .DW (DW)
  ) u_ramp (
    .clock_in   (clock_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (tick),
    .bypass_in  (bypass),
    .target_in  (tgt),
    .up_step_in (up_step),
    .dn_step_in (dn_step),
    .level_out  (level)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      jst_q     <= pjr_pkg::JST_IDLE;
      tick_q    <= '0;
      ref_q     <= '0;
      cur_q     <= 1'b0;
      pre_act_q <= 1'b0;
      jog_act_q <= 1'b0;
    end else begin
      jst_q     <= jst_d;
      tick_q    <= tick_d;
      ref_q     <= level;
      cur_q     <= is_current;
      pre_act_q <= sel != 3'h0 && jst_q == pjr_pkg::JST_IDLE;
      jog_act_q <= jst_q == pjr_pkg::JST_JOG;
    end
  end

  assign reg_rdata_out      = rdata_q;
  assign ref_out            = ref_q;
  assign ref_is_current_out = cur_q;
  assign preset_active_out  = pre_act_q;
  assign jog_active_out     = jog_act_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_preset_clamp_hi: assert property ( // [RULE1]
    reg_wr_in && reg_addr_in == pjr_pkg::A_PRESET0 &&
    $signed(reg_wdata_in) > pjr_pkg::REF_MAX
    |=> preset_q[0] == pjr_pkg::REF_MAX)
    else $error("preset not clamped to upper limit");
  a_preset_pick: assert property ( // [RULE2]
    jst_q == pjr_pkg::JST_IDLE && run_in && sel != 3'h0 &&
    !hit[pjr_pkg::FI_REV] |-> tgt == preset_q[sel - 3'h1])
    else $error("selected preset not used as setpoint");
  a_reverse_sign: assert property ( // [RULE3]
    jst_q == pjr_pkg::JST_IDLE && run_in && hit[pjr_pkg::FI_REV]
    |-> tgt == -$signed(sel == 3'h0 ? main_q : preset_q[sel - 3'h1]))
    else $error("reverse did not flip reference sign");
  a_follow_current: assert property ( // [RULE4]
    hit[pjr_pkg::FI_FOL] || cmode_q == pjr_pkg::CMODE_IREF
    |=> ref_is_current_out)
    else $error("current reference flag missing");
  a_sel_bit_a: assert property ( // [RULE7]
    din_in[0] && fn_q[0] == pjr_pkg::FN_PSA |-> sel[0])
    else $error("closed selector input A not seen");
  a_jmode_legal: assert property ( // [RULE10]
    jmode_q <= pjr_pkg::JMODE_SEPARATE)
    else $error("jog ramp mode out of range");
  a_jog_release: assert property ( // [RULE11]
    jst_q == pjr_pkg::JST_JOG && !jog_on &&
    jmode_q != pjr_pkg::JMODE_DIRECT |=> jst_q == pjr_pkg::JST_STOP)
    else $error("jog release did not enter stop ramp");
  a_direct_jog: assert property ( // [RULE12]
    bypass |-> ##2 ref_out == $past(tgt, 2))
    else $error("direct jog reference not passed through");
  a_jog_sep_acc: assert property ( // [RULE13]
    jst_q == pjr_pkg::JST_JOG && jmode_q == pjr_pkg::JMODE_SEPARATE
    |-> up_step == rate_q[pjr_pkg::R_JOG_ACC])
    else $error("separate jog acceleration not used");
  a_jog_sep_dec: assert property ( // [RULE14]
    jst_q == pjr_pkg::JST_STOP && jmode_q == pjr_pkg::JMODE_SEPARATE
    |-> dn_step == rate_q[pjr_pkg::R_JOG_DEC])
    else $error("separate jog deceleration not used on release");
  a_jog_bit_b: assert property ( // [RULE15]
    din_in[1] && fn_q[1] == pjr_pkg::FN_JOG_SEL_BIT_B |-> jsel[1])
    else $error("closed jog input B not seen");

  c_preset_run: cover property (
    run_in && sel == 3'h7 ##1 preset_active_out);
  c_direct_jog: cover property (bypass ##2 jog_active_out);
  c_stop_done: cover property (
    jst_q == pjr_pkg::JST_STOP ##1 jst_q == pjr_pkg::JST_IDLE);
  c_follower: cover property (hit[pjr_pkg::FI_FOL] ##1 ref_is_current_out);

endmodule : pjr_preset_jog_select

// file: sim/pjr_terminal_model.sv
module pjr_terminal_model (
  input  wire logic       clock_in,
  input  wire logic [2:0] sel_in,
  input  wire logic [1:0] jog_in,
  input  wire logic       rev_in,
  input  wire logic       fol_in,
  input  wire logic       run_req_in,
  output logic      [7:0] din_out,
  output logic            run_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // terminals: 0..2 preset bits, 3 follower, 4 reverse, 5..6 jog bits
  always @(posedge clock_in) begin
    din_out <= {1'b0, jog_in, rev_in, fol_in, sel_in};
    run_out <= run_req_in | (sel_in != 3'h0);
  end
endmodule : pjr_terminal_model

// file: sim/test_pjr_preset_jog_select.sv
module test_pjr_preset_jog_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock_in, rst_b_in, reg_wr_in, reg_rd_in;
  logic        [5:0]  reg_addr_in;
  logic        [15:0] reg_wdata_in, reg_rdata_out;
  logic        [7:0]  din_in;
  logic               run_in, ref_is_current_out;
  logic               preset_active_out, jog_active_out;
  logic signed [15:0] ref_out, main_v;
  logic signed [15:0] pre_v [7];
  logic        [2:0]  sel_r;
  logic        [1:0]  jog_r;
  logic               rev_r, fol_r, run_r;
  int                 miscompares, checks_done;

  pjr_preset_jog_select #(.TICK_CYCLES(4)) pjr_preset_jog_select_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .din_in(din_in), .run_in(run_in), .ref_out(ref_out),
    .ref_is_current_out(ref_is_current_out),
    .preset_active_out(preset_active_out),
    .jog_active_out(jog_active_out));

  pjr_terminal_model pjr_terminal_model_i (
    .clock_in(clock_in), .sel_in(sel_r), .jog_in(jog_r), .rev_in(rev_r),
    .fol_in(fol_r), .run_req_in(run_r), .din_out(din_in),
    .run_out(run_in));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk(reg_rdata_out, e, "register read");
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_cyc

  // waits for the next ramp tick and checks the size of the move
  task automatic step_chk(input logic [15:0] d);
    logic signed [15:0] old;
    int                 n;
    #1;
    old = ref_out;
    n = 0;
    while (ref_out === old && n < 20) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(ref_out - old, d, "ramp step");
  endtask : step_chk

  function automatic logic [15:0] exp_ref(input logic [2:0] s,
                                          input logic r);
    logic signed [15:0] v;
    v = (s == 3'h0) ? main_v : pre_v[s - 3'h1];
    return r ? -v : v;
  endfunction : exp_ref

  task automatic sel_chk(input logic [2:0] s, input logic r);
    sel_r <= s;
    rev_r <= r;
    wait_cyc(30);
    chk(ref_out, exp_ref(s, r), "selected reference");
    chk({15'h0, preset_active_out}, {15'h0, s != 3'h0}, "preset flag");
  endtask : sel_chk

  initial begin
    logic [15:0] rates [8];
    rates = '{16'h0014, 16'h000A, 16'h000A, 16'h000A, 16'h001E,
              16'h000A, 16'h0028, 16'h0032};
    {rst_b_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {sel_r, jog_r, rev_r, fol_r, run_r} = '0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(96));
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(pjr_pkg::A_PRESET0 + 6'(i), pjr_pkg::PRESET_RST[i]);
    end
    rd_chk(pjr_pkg::A_JMODE, 16'h0000);
    rd_chk(6'h3F, 16'h0000);
    wr(pjr_pkg::A_PRESET0, 16'h3000);
    rd_chk(pjr_pkg::A_PRESET0, 16'h2710);
    wr(pjr_pkg::A_PRESET0, 16'hC000);
    rd_chk(pjr_pkg::A_PRESET0, 16'hD8F0);
    wr(pjr_pkg::A_JMODE, 16'h0003);
    rd_chk(pjr_pkg::A_JMODE, 16'h0000);
    wr(pjr_pkg::A_JMODE, 16'h0002);
    rd_chk(pjr_pkg::A_JMODE, 16'h0002);
    rd_chk(pjr_pkg::A_STATUS, 16'h0008);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(pjr_pkg::A_FN0 + 6'(i), {12'h000, pjr_pkg::FN_CODES[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(pjr_pkg::A_RATE0 + 6'(i), 16'h4E20);
    end
    for (int i = 0; i < 7; i++) begin
      pre_v[i] = 16'(int'($urandom_range(20000)) - 10000);
      wr(pjr_pkg::A_PRESET0 + 6'(i), pre_v[i]);
    end
    main_v = 16'(int'($urandom_range(20000)) - 10000);
    wr(pjr_pkg::A_MAIN, main_v);
    run_r <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      sel_chk(3'(s), 1'b0);
      if (s != 0) sel_chk(3'(s), 1'b1);
    end
    repeat (6) sel_chk(3'($urandom_range(7)), 1'b0);
    $display("test preset select done");
    wr(pjr_pkg::A_FN0 + 6'h2, 16'h0000);
    sel_r <= 3'h7;
    wait_cyc(30);
    chk(ref_out, pre_v[2], "select without bit c");
    wr(pjr_pkg::A_FN0 + 6'h1, 16'h0000);
    wait_cyc(30);
    chk(ref_out, pre_v[0], "select with bit a only");
    $display("test unassigned bits done");
    fol_r <= 1'b1;
    wait_cyc(4);
    chk({15'h0, ref_is_current_out}, 16'h0001, "follower");
    fol_r <= 1'b0;
    wr(pjr_pkg::A_CMODE, {12'h000, pjr_pkg::CMODE_IREF});
    wait_cyc(4);
    chk({15'h0, ref_is_current_out}, 16'h0001, "current mode");
    wr(pjr_pkg::A_CMODE, 16'h0000);
    wait_cyc(4);
    chk({15'h0, ref_is_current_out}, 16'h0000, "speed mode");
    $display("test current reference done");
    sel_r <= 3'h0;
    main_v = 16'h0000;
    wr(pjr_pkg::A_MAIN, 16'h0000);
    wr(pjr_pkg::A_JMODE, 16'h0001);
    for (int j = 1; j < 4; j++) begin
      jog_r <= 2'(j);
      wait_cyc(6);
      chk(ref_out, pjr_pkg::JOG_RST[j-1], "direct jog");
      chk({15'h0, jog_active_out}, 16'h0001, "jog flag");
    end
    jog_r <= 2'h0;
    wait_cyc(30);
    $display("test direct jog done");
    for (int i = 0; i < 8; i++) begin
      wr(pjr_pkg::A_RATE0 + 6'(i), rates[i]);
    end
    wr(pjr_pkg::A_JMODE, 16'h0000);
    jog_r <= 2'h1;
    step_chk(16'h0014);
    wait_cyc(120);
    chk(ref_out, 16'h01F4, "shared ramp end");
    jog_r <= 2'h0;
    step_chk(16'hFFE2);
    wait_cyc(100);
    wr(pjr_pkg::A_JMODE, 16'h0002);
    jog_r <= 2'h1;
    step_chk(16'h0028);
    wait_cyc(80);
    wr(pjr_pkg::A_JOG0, 16'h00C8);
    step_chk(16'hFFCE);
    wait_cyc(40);
    chk(ref_out, 16'h00C8, "jog ramp end");
    jog_r <= 2'h0;
    step_chk(16'hFFCE);
    $display("test jog ramps done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : test_pjr_preset_jog_select
